//--- shared/sqc_pkg.sv
package sqc_pkg;

  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
  localparam logic [14:0] MS_LAST = 15'(CYC_PER_MS - 1);
  // One 16th step at tempo T lasts TICK_SCALE / T cycles
  localparam int unsigned TICK_SCALE = CLK_HZ / 4 * 60;
  localparam logic [29:0] SW_UNIT = 30'(TICK_SCALE / 50);
  localparam logic [9:0] BLINK_MS = 10'h258;
  localparam logic [9:0] BRIEF_MS = 10'h064;
  localparam logic [9:0] COPY_MS = 10'h3E8;
  localparam logic [2:0] CLKO_MS = 3'h5;

  localparam logic [6:0] LEN_MIN = 7'h01;
  localparam logic [6:0] LEN_MAX = 7'h40;
  localparam logic [6:0] SLOT_MAX = 7'h63;
  localparam logic [6:0] SWING_RST = 7'h32;
  localparam logic [6:0] SWING_MAX = 7'h4B;
  localparam logic [6:0] SWING_FULL = 7'h64;
  localparam logic [7:0] TEMPO_MIN = 8'h1E;
  localparam logic [7:0] TEMPO_MAX = 8'hF0;
  localparam logic signed [6:0] XPOSE_MAX = 7'sh24;
  localparam logic [7:0] DUR_CLR = 8'h50;
  localparam logic [8:0] PITCH_BASE = 9'h024;
  localparam logic [8:0] SEMI_PER_OCT = 9'h00C;
  localparam logic [2:0] FAC_LAST = 3'h4;
  localparam logic [6:0] LEN_LIST [8] = '{7'h04, 7'h08, 7'h0C, 7'h10, 7'h18, 7'h20, 7'h30, 7'h40};

  // Step buttons (0-based) that carry shift functions
  localparam logic [3:0] BTN_TEMPO = 4'h8;
  localparam logic [3:0] BTN_LEN = 4'h9;
  localparam logic [3:0] BTN_SWING = 4'hB;
  localparam logic [3:0] BTN_XPOSE = 4'hC;
  localparam logic [3:0] BTN_CLEAR = 4'hD;
  localparam logic [3:0] BTN_FAC = 4'hE;

  typedef struct packed {
    logic act;
    logic [3:0] pitch;
    logic [2:0] oct;
    logic [7:0] dur;
    logic [7:0] cv;
  } sqc_step_t;
  localparam sqc_step_t STEP_CLR = '{1'b0, 4'h0, 3'h0, DUR_CLR, 8'h00};

  typedef struct packed {
    logic [6:0] len;
    logic [7:0] tempo;
    logic [6:0] swing;
    logic signed [6:0] xpose;
  } sqc_cfg_t;
  localparam sqc_cfg_t CFG_RST = '{7'h10, 8'h78, SWING_RST, 7'sh00};

  typedef struct packed {
    logic play;
    logic shift;
    logic save;
    logic load;
    logic rec;
    logic [15:0] step;
  } sqc_btn_t;

  // move bits: 0 pitch, 1 octave, 2 duration, 3 cv
  typedef struct packed {
    logic [3:0] move;
    logic [3:0] pitch;
    logic [2:0] oct;
    logic [7:0] dur;
    logic [7:0] cv;
  } sqc_knob_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01, ST_SSEL = 6'h02, ST_LSEL = 6'h04,
    ST_SAVE = 6'h08, ST_LOAD = 6'h10, ST_BCPY = 6'h20
  } sqc_state_t;

  typedef enum logic [4:0] {
    PRM_NONE = 5'h01, PRM_TEMPO = 5'h02, PRM_LEN = 5'h04, PRM_SWING = 5'h08, PRM_XPOSE = 5'h10
  } sqc_prm_t;

  typedef enum logic [2:0] {
    DSP_NUM = 3'h0, DSP_COPY_DONE_INDICATION = 3'h1, DSP_ERASE_PROMPT_TEXT = 3'h2,
    DSP_E = 3'h3, DSP_ER = 3'h4, DSP_ERS_BLINK = 3'h5
  } sqc_disp_t;

  function automatic logic [7:0] bump(input logic [7:0] v, input logic up, input logic [7:0] lo,
                                      input logic [7:0] hi);
    if (up)
      bump = (v >= hi) ? hi : v + 8'h01;
    else
      bump = (v <= lo) ? lo : v - 8'h01;
  endfunction

  function automatic logic [6:0] len_jump(input logic [6:0] len, input logic up);
    len_jump = len;
    for (int i = 0; i < 8; i++)
      if (up && LEN_LIST[i] > len && len_jump == len)
        len_jump = LEN_LIST[i];
    for (int i = 7; i >= 0; i--)
      if (!up && LEN_LIST[i] < len && len_jump == len)
        len_jump = LEN_LIST[i];
  endfunction

endpackage

//--- verilog/sqc_core.sv
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// (R1) Each play press toggles internal playback running or stopped.
// (R2) Shift+play or reset trigger rewinds to step 1; next play/clock restarts.
// (R3) An external clock pulse stops the internal tempo; external clock drives playback.
// (R4) Save: press, pick slot 0-99 with data knob, press again; shift cancels; dp marks used.
// (R5) Double save overwrites last-used slot; double load reloads it.
// (R6) Load: press, pick slot, press again; an empty slot loads a blank sequence.
// (R7) Loading during playback keeps the current position.
// (R8) Step press selects and activates; pressing selected step again deactivates.
// (R9) Selected LED blinks mostly on/off by state; playing step flashes.
// (R10) Only active steps fire gate and update pitch and CV.
// (R11) Length ranges 1 to 64, default 16.
// (R12) With shift held the knob jumps common lengths; otherwise single steps.
// (R13) Shift plus buttons 1-4 page to bars 1-4.
// (R14) Steps beyond the length never play.
// (R15) Shift+source+destination copies a bar, then flashes a copy indication.
// (R16) Record held in playback writes first moved knob into active steps.
// (R17) Shift held, record taps activate the playing step.
// (R18) Loaded tempo applies only while paused.
// (R19) Swing delays even steps; 50 is straight; clock output is swung.
// (R20) Transpose offsets pitch in semitones, plus or minus 36.
// (R21) Clear deactivates all steps, zeroes pitch/octave/CV, duration 80.
// (R22) Shift+15 five times: prompt, three letters, blink, then factory erase.
// (R23) Each external clock rising edge advances one step, wrapping at length.
module sqc_core (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Front panel
  input wire sqc_pkg::sqc_btn_t btn,
  input wire logic data_up,
  input wire logic data_dn,
  input wire sqc_pkg::sqc_knob_t knob,
  // Jacks
  input wire logic ext_clk_in,
  input wire logic reset_trig_in,
  output logic gate_out,
  output logic [7:0] pitch_out,
  output logic [7:0] cv_out,
  output logic clk_out,
  // Indicators
  output logic [15:0] step_led,
  output sqc_pkg::sqc_disp_t disp_code,
  output logic [7:0] disp_num,
  output logic disp_dp,
  output logic playing,
  output logic ext_sync,
  output logic [5:0] play_pos
);

  function automatic logic [3:0] first_idx(input logic [15:0] v);
    first_idx = 4'h0;
    for (int i = 15; i >= 0; i--)
      if (v[i])
        first_idx = 4'(i);
  endfunction

  // Roughly p * pct / 100, using 41/4096 to avoid a divider
  function automatic logic [25:0] scale(input logic [25:0] p, input logic [7:0] pct);
    logic [46:0] m;
    m = 47'(p) * 47'(pct) * 47'h29;
    scale = m[37:12];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  sqc_pkg::sqc_btn_t prev_q;
  logic ext_prev_q, trg_prev_q;
  sqc_pkg::sqc_state_t st_q;
  sqc_pkg::sqc_prm_t prm_q;
  sqc_pkg::sqc_cfg_t cfg_q;
  sqc_pkg::sqc_step_t seq_mem [64];
  sqc_pkg::sqc_step_t pat_mem [6400];
  sqc_pkg::sqc_cfg_t hdr_mem [100];
  logic [99:0] occ_q;
  logic [6:0] slot_q, last_q;
  logic [5:0] xf_q, sel_q, pos_q;
  logic [1:0] bar_q, src_q, dst_q;
  logic run_q, ext_q, rpend_q, dpend_q;
  logic [29:0] acc_q;
  logic [25:0] per_cnt_q, per_q, gate_q, dly_q;
  logic [3:0] mrk_q;
  logic [2:0] fac_q, clko_q;
  logic [14:0] ms_cnt_q;
  logic [9:0] blink_q, copy_q;
  logic [15:0] led_d;
  sqc_pkg::sqc_disp_t disp_d;
  logic [7:0] num_d;
  logic dp_d;

  ////////////////////////////////////////////////////////////////////////////
  // Panel decode
  wire play_pr = btn.play & ~prev_q.play;
  wire save_pr = btn.save & ~prev_q.save;
  wire load_pr = btn.load & ~prev_q.load;
  wire rec_pr = btn.rec & ~prev_q.rec;
  wire shift_pr = btn.shift & ~prev_q.shift;
  wire ext_pr = ext_clk_in & ~ext_prev_q;
  wire trg_pr = reset_trig_in & ~trg_prev_q;
  wire [15:0] stp_pr = btn.step & ~prev_q.step;
  wire [3:0] stp_k = first_idx(stp_pr);
  wire stp_any = |stp_pr;
  wire idle = st_q == sqc_pkg::ST_IDLE;
  wire sh_k = btn.shift & stp_any & idle;
  wire ed_pr = ~btn.shift & stp_any & idle;
  wire [5:0] ed_idx = {bar_q, stp_k};
  wire [3:0] held_bar = prev_q.step[3:0] & btn.step[3:0] & ~stp_pr[3:0];
  wire bar_key = sh_k & (stp_k < 4'h4);
  wire bcp_go = bar_key & (|held_bar);
  wire clr_go = sh_k & (stp_k == sqc_pkg::BTN_CLEAR);
  wire fac_hit = sh_k & (stp_k == sqc_pkg::BTN_FAC);
  wire fac_go = fac_hit & (fac_q == sqc_pkg::FAC_LAST);
  wire rec_on = btn.rec & run_q;
  wire rhy_go = btn.shift & rec_pr & run_q;
  wire sv_commit = (st_q == sqc_pkg::ST_SSEL) & save_pr;
  wire ld_commit = (st_q == sqc_pkg::ST_LSEL) & load_pr;
  wire knob_dir = data_up;
  wire knob_any = data_up ^ data_dn;
  wire ms_en = ms_cnt_q == sqc_pkg::MS_LAST;
  wire brief = blink_q < sqc_pkg::BRIEF_MS;

  ////////////////////////////////////////////////////////////////////////////
  // Step timing
  wire [5:0] nxt = (7'(pos_q) + 7'h01 >= cfg_q.len) ? 6'h00 : pos_q + 6'h01; // [R14] [R23]
  wire [5:0] tgt = rpend_q ? 6'h00 : nxt;
  wire even_nxt = tgt[0];
  wire [6:0] sw_pct = even_nxt ? cfg_q.swing : sqc_pkg::SWING_FULL - cfg_q.swing;
  wire [29:0] thr = sqc_pkg::SW_UNIT * {23'h0, sw_pct}; // [R19]
  wire int_adv = run_q & ~ext_q & ((acc_q >= thr) | rpend_q);
  wire swung = even_nxt & (cfg_q.swing > sqc_pkg::SWING_RST);
  wire ext_now = ext_pr & ~dpend_q & ~swung;
  wire adv = int_adv | ext_now | (dpend_q & (dly_q == 26'h0)); // [R3] [R23]
  wire sqc_pkg::sqc_step_t cur = seq_mem[tgt];
  wire [8:0] pitch_sum = sqc_pkg::PITCH_BASE + 9'(cur.oct) * sqc_pkg::SEMI_PER_OCT + 9'(cur.pitch)
                         + 9'(cfg_q.xpose); // [R20]

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      prev_q <= '0;
      ext_prev_q <= 1'b0;
      trg_prev_q <= 1'b0;
      ms_cnt_q <= 15'h0000;
      blink_q <= 10'h000;
    end
    else
    begin
      prev_q <= btn;
      ext_prev_q <= ext_clk_in;
      trg_prev_q <= reset_trig_in;
      ms_cnt_q <= ms_en ? 15'h0000 : ms_cnt_q + 15'h0001;
      if (ms_en)
        blink_q <= (blink_q == sqc_pkg::BLINK_MS - 10'h001) ? 10'h000 : blink_q + 10'h001;
    end
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      run_q <= 1'b0;
      ext_q <= 1'b0;
      rpend_q <= 1'b1;
      pos_q <= 6'h00;
      acc_q <= 30'h0;
    end
    else
    begin
      if (play_pr & ~btn.shift)
      begin
        run_q <= ~run_q; // [R1]
        ext_q <= 1'b0;
      end
      if ((play_pr & btn.shift) | trg_pr)
        run_q <= 1'b0; // [R2]
      if (ext_pr)
      begin
        ext_q <= 1'b1; // [R3]
        run_q <= 1'b1;
      end
      if ((play_pr & btn.shift) | trg_pr)
        rpend_q <= 1'b1; // [R2]
      else if (adv)
        rpend_q <= 1'b0;
      if (adv)
        pos_q <= tgt;
      acc_q <= (~run_q | ext_q | adv) ? 30'h0 : acc_q + 30'(cfg_q.tempo);
    end
  end

  // Output side of each step: gate length, swing delay on external clock, clock out
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      per_cnt_q <= 26'h0;
      per_q <= 26'h0;
      gate_q <= 26'h0;
      dly_q <= 26'h0;
      dpend_q <= 1'b0;
      clko_q <= 3'h0;
      pitch_out <= 8'h00;
      cv_out <= 8'h00;
    end
    else
    begin
      if (adv)
        per_cnt_q <= 26'h0;
      else if (~&per_cnt_q)
        per_cnt_q <= per_cnt_q + 26'h1;
      if (adv)
        per_q <= per_cnt_q;
      if (adv & cur.act)
      begin
        gate_q <= scale(per_q, cur.dur); // [R10]
        pitch_out <= pitch_sum[7:0];
        cv_out <= cur.cv;
      end
      else if (gate_q != 26'h0)
        gate_q <= gate_q - 26'h1;
      if (ext_pr & ~dpend_q & swung)
      begin
        dpend_q <= 1'b1; // [R19]
        dly_q <= scale(per_q, {cfg_q.swing - sqc_pkg::SWING_RST, 1'b0});
      end
      else if (dpend_q & (dly_q == 26'h0))
        dpend_q <= 1'b0;
      else if (dpend_q)
        dly_q <= dly_q - 26'h1;
      if (adv)
        clko_q <= sqc_pkg::CLKO_MS; // [R19]
      else if (ms_en & (clko_q != 3'h0))
        clko_q <= clko_q - 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Patch transfer engine
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st_q <= sqc_pkg::ST_IDLE;
      slot_q <= 7'h00;
      last_q <= 7'h00;
      xf_q <= 6'h00;
      src_q <= 2'h0;
      dst_q <= 2'h0;
      occ_q <= '0;
      copy_q <= 10'h000;
    end
    else
    begin
      if (ms_en & (copy_q != 10'h000))
        copy_q <= copy_q - 10'h001;
      case (st_q)
        sqc_pkg::ST_IDLE:
        begin
          xf_q <= 6'h00;
          slot_q <= last_q; // [R5]
          if (save_pr)
            st_q <= sqc_pkg::ST_SSEL; // [R4]
          else if (load_pr)
            st_q <= sqc_pkg::ST_LSEL; // [R6]
          else if (bcp_go)
          begin
            st_q <= sqc_pkg::ST_BCPY; // [R15]
            src_q <= 2'(first_idx({12'h000, held_bar}));
            dst_q <= stp_k[1:0];
          end
          if (fac_go)
            occ_q <= '0; // [R22]
        end
        sqc_pkg::ST_SSEL, sqc_pkg::ST_LSEL:
        begin
          if (knob_any)
            slot_q <= 7'(sqc_pkg::bump({1'b0, slot_q}, knob_dir, 8'h00, {1'b0, sqc_pkg::SLOT_MAX}));
          if (shift_pr)
            st_q <= sqc_pkg::ST_IDLE; // [R4]
          else if (sv_commit)
          begin
            st_q <= sqc_pkg::ST_SAVE;
            occ_q[slot_q] <= 1'b1;
            last_q <= slot_q;
          end
          else if (ld_commit)
          begin
            st_q <= sqc_pkg::ST_LOAD;
            last_q <= slot_q;
          end
        end
        sqc_pkg::ST_SAVE, sqc_pkg::ST_LOAD:
        begin
          xf_q <= xf_q + 6'h01;
          if (xf_q == 6'h3F)
            st_q <= sqc_pkg::ST_IDLE;
        end
        sqc_pkg::ST_BCPY:
        begin
          xf_q <= xf_q + 6'h01;
          if (xf_q == 6'h0F)
          begin
            st_q <= sqc_pkg::ST_IDLE;
            copy_q <= sqc_pkg::COPY_MS; // [R15]
          end
        end
        default: st_q <= sqc_pkg::ST_IDLE;
      endcase
    end
  end

  // Patch memory has no reset; the occupied flags say what is valid
  always_ff @(posedge sys_clk)
  begin
    if (st_q == sqc_pkg::ST_SAVE)
      pat_mem[{slot_q, xf_q}] <= seq_mem[xf_q]; // [R4] [R5]
    if (sv_commit)
      hdr_mem[slot_q] <= cfg_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Active sequence
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 64; i++)
        seq_mem[i] <= sqc_pkg::STEP_CLR;
    end
    else if (st_q == sqc_pkg::ST_LOAD)
      seq_mem[xf_q] <= occ_q[slot_q] ? pat_mem[{slot_q, xf_q}] : sqc_pkg::STEP_CLR; // [R6] [R7]
    else if (st_q == sqc_pkg::ST_BCPY)
      seq_mem[{dst_q, xf_q[3:0]}] <= seq_mem[{src_q, xf_q[3:0]}]; // [R15]
    else if (clr_go | fac_go)
    begin
      for (int i = 0; i < 64; i++)
        seq_mem[i] <= sqc_pkg::STEP_CLR; // [R21]
    end
    else
    begin
      if (ed_pr)
        seq_mem[ed_idx].act <= ~((ed_idx == sel_q) & seq_mem[ed_idx].act); // [R8]
      if (~btn.rec & knob.move[0])
        seq_mem[sel_q].pitch <= knob.pitch;
      if (~btn.rec & knob.move[1])
        seq_mem[sel_q].oct <= knob.oct;
      if (~btn.rec & knob.move[2])
        seq_mem[sel_q].dur <= knob.dur;
      if (~btn.rec & knob.move[3])
        seq_mem[sel_q].cv <= knob.cv;
      // Motion recording touches only the first knob latched in this hold
      if (adv & rec_on & cur.act & mrk_q[0])
        seq_mem[tgt].pitch <= knob.pitch; // [R16]
      if (adv & rec_on & cur.act & mrk_q[1])
        seq_mem[tgt].oct <= knob.oct; // [R16]
      if (adv & rec_on & cur.act & mrk_q[2])
        seq_mem[tgt].dur <= knob.dur; // [R16]
      if (adv & rec_on & cur.act & mrk_q[3])
        seq_mem[tgt].cv <= knob.cv; // [R16]
      if (rhy_go)
        seq_mem[pos_q].act <= 1'b1; // [R17]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Editing state and sequence-wide settings
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      bar_q <= 2'h0;
      sel_q <= 6'h00;
      prm_q <= sqc_pkg::PRM_NONE;
      cfg_q <= sqc_pkg::CFG_RST; // [R11]
      mrk_q <= 4'h0;
      fac_q <= 3'h0;
    end
    else
    begin
      if (bar_key & ~bcp_go)
        bar_q <= stp_k[1:0]; // [R13]
      if (ed_pr)
        sel_q <= ed_idx; // [R8]
      if (~rec_on)
        mrk_q <= 4'h0;
      else if (mrk_q == 4'h0)
        mrk_q <= knob.move & (~knob.move + 4'h1); // [R16]
      if (fac_go)
        fac_q <= 3'h0;
      else if (fac_hit)
        fac_q <= fac_q + 3'h1; // [R22]
      else if (stp_any | ~btn.shift)
        fac_q <= 3'h0;
      if (shift_pr)
        prm_q <= sqc_pkg::PRM_NONE;
      else if (sh_k & (stp_k == sqc_pkg::BTN_TEMPO))
        prm_q <= sqc_pkg::PRM_TEMPO;
      else if (sh_k & (stp_k == sqc_pkg::BTN_LEN))
        prm_q <= sqc_pkg::PRM_LEN;
      else if (sh_k & (stp_k == sqc_pkg::BTN_SWING))
        prm_q <= sqc_pkg::PRM_SWING;
      else if (sh_k & (stp_k == sqc_pkg::BTN_XPOSE))
        prm_q <= sqc_pkg::PRM_XPOSE;
      if (fac_go)
        cfg_q <= sqc_pkg::CFG_RST; // [R22]
      else if (ld_commit)
      begin
        cfg_q <= occ_q[slot_q] ? hdr_mem[slot_q] : sqc_pkg::CFG_RST; // [R6]
        if (run_q | ext_q)
          cfg_q.tempo <= cfg_q.tempo; // [R18]
        else if (occ_q[slot_q])
          cfg_q.tempo <= hdr_mem[slot_q].tempo; // [R18]
      end
      else if (idle & knob_any)
      begin
        case (prm_q)
          sqc_pkg::PRM_TEMPO:
            cfg_q.tempo <= sqc_pkg::bump(cfg_q.tempo, knob_dir, sqc_pkg::TEMPO_MIN, sqc_pkg::TEMPO_MAX);
          sqc_pkg::PRM_LEN:
            cfg_q.len <= btn.shift ? sqc_pkg::len_jump(cfg_q.len, knob_dir) // [R12]
                       : 7'(sqc_pkg::bump({1'b0, cfg_q.len}, knob_dir, {1'b0, sqc_pkg::LEN_MIN},
                                          {1'b0, sqc_pkg::LEN_MAX})); // [R11]
          sqc_pkg::PRM_SWING:
            cfg_q.swing <= 7'(sqc_pkg::bump({1'b0, cfg_q.swing}, knob_dir, {1'b0, sqc_pkg::SWING_RST},
                                            {1'b0, sqc_pkg::SWING_MAX})); // [R19]
          sqc_pkg::PRM_XPOSE:
            if (knob_dir & (cfg_q.xpose < sqc_pkg::XPOSE_MAX))
              cfg_q.xpose <= cfg_q.xpose + 7'sh01; // [R20]
            else if (~knob_dir & (cfg_q.xpose > -sqc_pkg::XPOSE_MAX))
              cfg_q.xpose <= cfg_q.xpose - 7'sh01; // [R20]
          default: cfg_q <= cfg_q;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // LEDs and display
  always_comb
  begin
    led_d = 16'h0000;
    for (int i = 0; i < 16; i++)
    begin
      led_d[i] = seq_mem[{bar_q, 4'(i)}].act;
      if ({bar_q, 4'(i)} == sel_q)
        led_d[i] = led_d[i] ? ~brief : brief; // [R9]
      if ((run_q | ext_q) & ({bar_q, 4'(i)} == pos_q) & (clko_q != 3'h0))
        led_d[i] = ~led_d[i]; // [R9]
    end
  end

  // Slot selection always shows the number, so the decimal point is never paired with a text code
  assign disp_d = ((st_q == sqc_pkg::ST_SSEL) | (st_q == sqc_pkg::ST_LSEL)) ? sqc_pkg::DSP_NUM // [R4]
                : (copy_q != 10'h000) ? sqc_pkg::DSP_COPY_DONE_INDICATION // [R15]
                : (fac_q == 3'h1) ? sqc_pkg::DSP_ERASE_PROMPT_TEXT // [R22]
                : (fac_q == 3'h2) ? sqc_pkg::DSP_E
                : (fac_q == 3'h3) ? sqc_pkg::DSP_ER
                : (fac_q == 3'h4) ? sqc_pkg::DSP_ERS_BLINK : sqc_pkg::DSP_NUM;
  assign num_d = (~idle) ? {1'b0, slot_q}
               : (prm_q == sqc_pkg::PRM_TEMPO) ? cfg_q.tempo
               : (prm_q == sqc_pkg::PRM_LEN) ? {1'b0, cfg_q.len}
               : (prm_q == sqc_pkg::PRM_SWING) ? {1'b0, cfg_q.swing}
               : (prm_q == sqc_pkg::PRM_XPOSE) ? 8'(cfg_q.xpose) : {4'h0, seq_mem[sel_q].pitch};
  assign dp_d = ((st_q == sqc_pkg::ST_SSEL) | (st_q == sqc_pkg::ST_LSEL)) & occ_q[slot_q]; // [R4]

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      step_led <= 16'h0000;
      disp_code <= sqc_pkg::DSP_NUM;
      disp_num <= 8'h00;
      disp_dp <= 1'b0;
    end
    else
    begin
      step_led <= led_d;
      disp_code <= disp_d;
      disp_num <= num_d;
      disp_dp <= dp_d;
    end
  end

  assign gate_out = gate_q != 26'h0;
  assign clk_out = clko_q != 3'h0;
  assign playing = run_q;
  assign ext_sync = ext_q;
  assign play_pos = pos_q;

endmodule
`default_nettype wire

//--- verification/sqc_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module sqc_core_chk (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Panel and jacks
  input wire sqc_pkg::sqc_btn_t btn,
  input wire logic ext_clk_in,
  input wire logic reset_trig_in,
  // Results
  input wire logic gate_out,
  input wire logic clk_out,
  input wire sqc_pkg::sqc_disp_t disp_code,
  input wire logic disp_dp,
  input wire logic playing,
  input wire logic ext_sync,
  input wire logic [5:0] play_pos
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////
  a_rst_clean: assert property ($fell(rst) |-> !playing && !ext_sync && !gate_out && play_pos == 6'h00)
    else $error("outputs not clear after reset");
  a_play_toggles: assert property ($rose(btn.play) && !btn.shift && !$rose(ext_clk_in) |=> playing != $past(playing))
    else $error("play press did not toggle run");
  a_play_unsync: assert property ($rose(btn.play) && !btn.shift && !$rose(ext_clk_in) |=> !ext_sync)
    else $error("play press left external sync on");
  a_ext_takes: assert property ($rose(ext_clk_in) && !btn.play |-> ##[1:2] (ext_sync && playing))
    else $error("external clock not followed");
  a_trig_stops: assert property ($rose(reset_trig_in) && !$rose(ext_clk_in) && !$rose(btn.play) |=> !playing)
    else $error("reset trigger did not stop run");
  a_dp_select: assert property (disp_dp |-> disp_code == sqc_pkg::DSP_NUM)
    else $error("decimal point outside slot number");
  a_clk_width: assert property ($rose(clk_out) |=> clk_out [*8])
    else $error("clock output pulse too short");
  a_gate_run: assert property ($rose(gate_out) |-> playing || ext_sync)
    else $error("gate fired while stopped");
  // Shift is excluded, though a rewind only sets rpend_q and does not move the position while stopped
  a_stop_still: assert property (!playing && !ext_sync && !$rose(ext_clk_in) && !$rose(btn.play) && !btn.shift
    |=> $stable(play_pos))
    else $error("position moved while stopped");
  ////////////////////////////////////////////////////////////
  c_ext_run: cover property ($rose(ext_sync));
  c_gate: cover property ($rose(gate_out));
  c_copy: cover property (disp_code == sqc_pkg::DSP_COPY_DONE_INDICATION);
endmodule
bind sqc_core sqc_core_chk u_chk (.sys_clk, .rst, .btn, .ext_clk_in, .reset_trig_in, .gate_out, .clk_out,
  .disp_code, .disp_dp, .playing, .ext_sync, .play_pos);
`default_nettype wire

//--- verification/sqc_panel.sv
`timescale 1ns/1ps
`default_nettype none
module sqc_panel (
  // Clock
  input wire logic sys_clk,
  // Buttons and jacks
  output var sqc_pkg::sqc_btn_t btn,
  output logic ext_clk_in,
  output logic reset_trig_in
);
  initial
  begin
    btn = '0;
    ext_clk_in = 1'b0;
    reset_trig_in = 1'b0;
  end
  // One quiet cycle before and two after each press so every edge is seen alone
  task automatic hit(input logic [20:0] held, input logic [20:0] b);
    @(negedge sys_clk) btn = held;
    @(negedge sys_clk) btn = held | b;
    repeat (2) @(negedge sys_clk);
    btn = held;
    repeat (2) @(negedge sys_clk);
  endtask
  // Fixed spacing keeps an 80% gate shorter than the next interval
  task automatic tick();
    repeat (28) @(negedge sys_clk);
    ext_clk_in = 1'b1;
    @(negedge sys_clk) ext_clk_in = 1'b0;
  endtask
  task automatic trig();
    @(negedge sys_clk) reset_trig_in = 1'b1;
    @(negedge sys_clk) reset_trig_in = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [20:0] PLAY = 21'h100000;
  localparam logic [20:0] SHIFT = 21'h080000;
  localparam logic [20:0] SAVE = 21'h040000;
  logic sys_clk, rst, ext_clk_in, reset_trig_in, gate_out, clk_out, disp_dp, playing, ext_sync;
  logic [7:0] pitch_out, cv_out, disp_num;
  logic data_up = 1'b0;
  logic [15:0] step_led, act, m;
  logic [5:0] play_pos;
  sqc_pkg::sqc_btn_t btn;
  sqc_pkg::sqc_disp_t disp_code;
  int n_errors = 0;
  int total_checks = 0;
  int pos, sel, lastp, k;

  sqc_panel u_panel (.sys_clk, .btn, .ext_clk_in, .reset_trig_in);
  sqc_core DUT (.sys_clk, .rst, .btn, .data_up, .data_dn(1'b0), .knob('0), .ext_clk_in, .reset_trig_in,
    .gate_out, .pitch_out, .cv_out, .clk_out, .step_led, .disp_code, .disp_num, .disp_dp, .playing,
    .ext_sync, .play_pos);
  ////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial
  begin
    #2000000;
    n_errors++;
    $display("MISMATCH %0t watchdog expired", $time);
    end_of_test();
  end
  initial
  begin
    rst = 1'b1;
    act = '0;
    sel = 0;
    lastp = 0;
    void'($urandom(32'h1C13));
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    @(negedge sys_clk);
    check(16'(play_pos), 16'h0000);
    check(16'(playing), 16'h0000);
    done("reset");
    // Fifth press erases and drops the display back to the number
    for (int i = 2; i < 7; i++)
    begin
      u_panel.hit(SHIFT, 21'h004000);
      check(16'(disp_code), 16'(i % 6));
    end
    u_panel.hit('0, '0);
    done("factory");
    for (int i = 0; i < 6; i++)
    begin
      k = sel;
      while (k == sel)
        // Step 1 stays inactive: its gate would span the long first interval after the idle start
        k = 2 + int'($urandom % 14);
      act[k] = 1'b1;
      sel = k;
      u_panel.hit('0, 21'(1 << k));
    end
    u_panel.hit('0, 21'(1 << sel));
    act[sel] = 1'b0;
    m = ~(16'h0001 << sel);
    check(step_led & m, act);
    done("steps");
    for (int i = 0; i < 40; i++)
    begin
      u_panel.tick();
      pos = (i == 0) ? 0 : (pos + 1) % 16;
      lastp = act[pos] ? 36 : lastp;
      check(16'(play_pos), 16'(pos));
      check(16'(gate_out), 16'(act[pos]));
      check(16'(pitch_out), 16'(lastp));
      check(16'(cv_out), 16'h0000);
    end
    check(16'(ext_sync), 16'h0001);
    u_panel.trig();
    @(negedge sys_clk);
    check(16'(playing), 16'h0000);
    u_panel.tick();
    check(16'(play_pos), 16'h0000);
    done("external clock");
    u_panel.hit('0, PLAY);
    check(16'(playing), 16'h0000);
    u_panel.hit('0, PLAY);
    check(16'(playing), 16'h0001);
    repeat (3) u_panel.tick();
    check(16'(play_pos), 16'h0003);
    u_panel.hit(SHIFT, PLAY);
    u_panel.hit('0, '0);
    u_panel.hit('0, PLAY);
    check(16'(play_pos), 16'h0000);
    done("play");
    u_panel.hit('0, SAVE);
    check(16'(disp_dp), 16'h0000);
    u_panel.hit('0, SAVE);
    repeat (70) @(negedge sys_clk);
    u_panel.hit('0, SAVE);
    check(16'(disp_dp), 16'h0001);
    u_panel.hit(SHIFT, '0);
    done("save");
    u_panel.hit(SHIFT, 21'h000002);
    check(step_led & m, 16'h0000);
    u_panel.hit(SHIFT | 21'h000001, 21'h000002);
    repeat (20) @(negedge sys_clk);
    check(16'(disp_code), 16'(sqc_pkg::DSP_COPY_DONE_INDICATION));
    u_panel.hit(SHIFT, 21'h000002);
    check(step_led & m, act);
    u_panel.hit('0, '0);
    done("bars");
    u_panel.hit(SHIFT, 21'h000200);
    @(negedge sys_clk) data_up = 1'b1;
    @(negedge sys_clk) data_up = 1'b0;
    @(negedge sys_clk);
    check(16'(disp_num), 16'h0018);
    u_panel.hit('0, '0);
    @(negedge sys_clk) data_up = 1'b1;
    @(negedge sys_clk) data_up = 1'b0;
    @(negedge sys_clk);
    check(16'(disp_num), 16'h0019);
    done("length");
    end_of_test();
  end
endmodule
`default_nettype wire
